//--- verilog/cmpdac_consts.svh
// Overview of operation
// - Level register bits 4-0 pick one of 32 reference ladder taps.
// - Level register bits 7-5 are unimplemented and read zero.
// - All implemented reference bits are read/write and clear to zero on reset.
// - Positive source field bits 3-2: 00 supply, 01 reference pin, 10 buffer, 11 reserved.
// - Reference control bits 4 and 1 read back as zero.
// - Raw comparison is high when non-inverting input exceeds inverting input.
// - Two independent comparators, each with its own pair of control registers.
// - Enable bit runs the comparator; clearing it powers the comparator down.
// - Result readable in each control A register and in a shared mirror register.
// - Pin carries result only with drive bit set, direction output, comparator on.
// - With drive bit set the result replaces the port latch value on the pin.
// - Enable bit does not change whether the pin override is in effect.
// - Internal result registered every cycle; pin path adds no register.
// - Reported result equals raw comparison XOR the invert bit while enabled, and the invert bit alone while disabled.
// - Two-bit positive input select: pin, reference output, buffer, ground.
// - Enabled rising or falling result edges set a flag that software clears.
`ifndef CMPDAC_CONSTS_SVH
`define CMPDAC_CONSTS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CMPDAC_OFS_DAC_CTRL   6'h00
`define CMPDAC_OFS_DAC_LEVEL  6'h04
`define CMPDAC_OFS_CMP1_A     6'h08
`define CMPDAC_OFS_CMP1_B     6'h0C
`define CMPDAC_OFS_CMP2_A     6'h10
`define CMPDAC_OFS_CMP2_B     6'h14
`define CMPDAC_OFS_MIRROR     6'h18
`define CMPDAC_OFS_IRQ_STAT   6'h1C
`define CMPDAC_OFS_IRQ_MASK   6'h20

// ****************************************************************
// Field positions
// ****************************************************************
`define CMPDAC_DAC_ON_BIT     7
`define CMPDAC_DAC_LPS_BIT    6
`define CMPDAC_DAC_DRV_BIT    5
`define CMPDAC_DAC_PSS_HI     3
`define CMPDAC_DAC_PSS_LO     2
`define CMPDAC_DAC_NSS_BIT    0
`define CMPDAC_LEVEL_HI       4
`define CMPDAC_CMP_ON_BIT     7
`define CMPDAC_CMP_RES_BIT    6
`define CMPDAC_CMP_DRV_BIT    5
`define CMPDAC_CMP_INV_BIT    4
`define CMPDAC_CMP_RISE_BIT   7
`define CMPDAC_CMP_FALL_BIT   6
`define CMPDAC_CMP_PSEL_HI    1

// ****************************************************************
// Reset values and bus answers
// ****************************************************************
`define CMPDAC_RST_REG        8'h00
`define CMPDAC_RESP_OKAY      2'h0
`define CMPDAC_RESP_SLVERR    2'h2
`define CMPDAC_SYNC_STAGES    2

`endif

//--- verilog/cmpdac_pkg.sv
`default_nettype none
package cmpdac_pkg;

  typedef struct packed {
    logic       on;
    logic       lowpower_side_sel;
    logic       pin_drive;
    logic [1:0] pos_source_sel;
    logic       neg_source_sel;
    logic [4:0] level;
  } cmpdac_dac_cfg_t;

  typedef struct packed {
    logic       on;
    logic       pin_drive;
    logic       invert;
    logic       rise_irq_on;
    logic       fall_irq_on;
    logic [1:0] pos_input_sel;
  } cmpdac_cmp_cfg_t;

  typedef enum logic [1:0] {
    CMPDAC_WR_IDLE = 2'b01,
    CMPDAC_WR_RESP = 2'b10
  } cmpdac_wr_state_t;

  typedef enum logic [1:0] {
    CMPDAC_RD_IDLE = 2'b01,
    CMPDAC_RD_DATA = 2'b10
  } cmpdac_rd_state_t;

endpackage : cmpdac_pkg
`default_nettype wire

//--- verilog/cmpdac_sync.sv
`timescale 1ns/1ps
`default_nettype none
module cmpdac_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : cmpdac_sync
`default_nettype wire

//--- verilog/cmpdac_chan.sv
`timescale 1ns/1ps
`default_nettype none
module cmpdac_chan
  import cmpdac_pkg::*;
(
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire cmpdac_cmp_cfg_t cfg,
  input  wire logic            raw_sync,
  output var  logic            result_q,
  output logic                 edge_set
);
  logic result_d;
  logic rise;
  logic fall;

  // A disabled comparator has its raw level masked low here, whatever level the analog side shows
  assign result_d = (raw_sync & cfg.on) ^ cfg.invert;
  assign rise     = result_d & ~result_q;
  assign fall     = ~result_d & result_q;
  assign edge_set = (rise & cfg.rise_irq_on) | (fall & cfg.fall_irq_on);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_q <= 1'b0;
    end else begin
      result_q <= result_d;
    end
  end
endmodule : cmpdac_chan
`default_nettype wire

//--- verilog/cmpdac_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "cmpdac_consts.svh"
module cmpdac_top
  import cmpdac_pkg::*;
#(
  parameter int ADDR_W  = 6,
  parameter int NUM_CMP = 2
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic [2:0]         s_axi_awprot,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output var  logic [1:0]         s_axi_bresp,
  output var  logic               s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [ADDR_W-1:0]  s_axi_araddr,
  input  wire logic [2:0]         s_axi_arprot,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output var  logic [31:0]        s_axi_rdata,
  output var  logic [1:0]         s_axi_rresp,
  output var  logic               s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // Analog side
  input  wire logic [NUM_CMP-1:0] cmp_raw,
  output cmpdac_cmp_cfg_t         cmp_cfg [NUM_CMP],
  output cmpdac_dac_cfg_t         dac_cfg,
  // Port pins
  input  wire logic [NUM_CMP-1:0] pin_direction,
  input  wire logic [NUM_CMP-1:0] port_latch,
  output logic [NUM_CMP-1:0]      cmp_pin_out,
  output logic [NUM_CMP-1:0]      cmp_pin_oe,
  // Interrupt
  output logic                    irq
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  // The register map reserves exactly two comparator slots
  generate
    if (NUM_CMP != 2) begin : g_bad_num
      $error("cmpdac_top: NUM_CMP must be 2");
    end
    if (ADDR_W < 6) begin : g_bad_addr
      $error("cmpdac_top: ADDR_W must be at least 6");
    end
    if (`CMPDAC_SYNC_STAGES != 2) begin : g_bad_sync
      $error("cmpdac_top: the synchroniser has exactly two stages");
    end
  endgenerate

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic logic [8:0] cmpdac_decode(input logic [ADDR_W-1:0] addr);
    logic [8:0] hit;
    hit = 9'h000;
    if ((addr >> 6) == '0) begin
      case (addr[5:0])
        `CMPDAC_OFS_DAC_CTRL:  hit = 9'h001;
        `CMPDAC_OFS_DAC_LEVEL: hit = 9'h002;
        `CMPDAC_OFS_CMP1_A:    hit = 9'h004;
        `CMPDAC_OFS_CMP1_B:    hit = 9'h008;
        `CMPDAC_OFS_CMP2_A:    hit = 9'h010;
        `CMPDAC_OFS_CMP2_B:    hit = 9'h020;
        `CMPDAC_OFS_MIRROR:    hit = 9'h040;
        `CMPDAC_OFS_IRQ_STAT:  hit = 9'h080;
        `CMPDAC_OFS_IRQ_MASK:  hit = 9'h100;
        default:               hit = 9'h000;
      endcase
    end
    return hit;
  endfunction : cmpdac_decode

  // ****************************************************************
  // Write channel
  // ****************************************************************
  cmpdac_wr_state_t  wr_state_q;
  cmpdac_wr_state_t  wr_state_d;
  logic              aw_held_q;
  logic              w_held_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0]        wdata_q;
  logic              wstrb0_q;
  logic              wr_fire;
  logic [8:0]        wr_hit;
  logic              wr_en;
  logic [7:0]        wd;
  logic              wr_dac_ctrl;
  logic              wr_dac_level;
  logic              wr_irq_stat;
  logic              wr_irq_mask;
  logic              wr_miss;

  // Address and data may arrive in either order; each is held until both exist
  assign s_axi_awready = (wr_state_q == CMPDAC_WR_IDLE) && !aw_held_q;
  assign s_axi_wready  = (wr_state_q == CMPDAC_WR_IDLE) && !w_held_q;
  assign wr_fire       = (wr_state_q == CMPDAC_WR_IDLE) && aw_held_q && w_held_q;
  assign wr_hit        = cmpdac_decode(awaddr_q);
  assign wr_en         = wr_fire && wstrb0_q;
  assign wd            = wdata_q;
  assign wr_dac_ctrl   = wr_en && wr_hit[0];
  assign wr_dac_level  = wr_en && wr_hit[1];
  assign wr_irq_stat   = wr_en && wr_hit[7];
  assign wr_irq_mask   = wr_en && wr_hit[8];
  // A hole in the map answers SLVERR and changes nothing
  assign wr_miss       = (wr_hit == 9'h000);

  always_comb begin
    wr_state_d = wr_state_q;
    case (wr_state_q)
      CMPDAC_WR_IDLE: if (wr_fire) wr_state_d = CMPDAC_WR_RESP;
      CMPDAC_WR_RESP: if (s_axi_bready) wr_state_d = CMPDAC_WR_IDLE;
      default:        wr_state_d = CMPDAC_WR_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_q <= CMPDAC_WR_IDLE;
      aw_held_q  <= 1'b0;
      w_held_q   <= 1'b0;
      awaddr_q   <= '0;
      wdata_q    <= 8'h00;
      wstrb0_q   <= 1'b0;
    end else begin
      wr_state_q <= wr_state_d;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `CMPDAC_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_miss ? `CMPDAC_RESP_SLVERR : `CMPDAC_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  cmpdac_dac_cfg_t dac_q;
  cmpdac_cmp_cfg_t cmp_q [NUM_CMP];
  logic [7:0]      irq_mask_q;
  logic [7:0]      irq_stat_q;
  logic [7:0]      irq_stat_d;
  logic [7:0]      irq_set;
  logic [7:0]      stat_clr;

  // Only implemented fields are stored, so spare positions stay zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dac_q <= '0;
    end else if (wr_dac_ctrl) begin
      dac_q.on                <= wd[`CMPDAC_DAC_ON_BIT];
      dac_q.lowpower_side_sel <= wd[`CMPDAC_DAC_LPS_BIT];
      dac_q.pin_drive         <= wd[`CMPDAC_DAC_DRV_BIT];
      dac_q.pos_source_sel    <= wd[`CMPDAC_DAC_PSS_HI:`CMPDAC_DAC_PSS_LO];
      dac_q.neg_source_sel    <= wd[`CMPDAC_DAC_NSS_BIT];
    end else if (wr_dac_level) begin
      dac_q.level <= wd[`CMPDAC_LEVEL_HI:0];
    end
  end

  assign dac_cfg = dac_q;

  genvar gi;
  // Each comparator owns two consecutive words: control A, then control B
  generate
    for (gi = 0; gi < NUM_CMP; gi++) begin : g_cmp_reg
      logic wr_ctrl_a;
      logic wr_ctrl_b;
      assign wr_ctrl_a = wr_en && wr_hit[2*gi+2];
      assign wr_ctrl_b = wr_en && wr_hit[2*gi+3];
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cmp_q[gi] <= '0;
        end else if (wr_ctrl_a) begin
          cmp_q[gi].on        <= wd[`CMPDAC_CMP_ON_BIT];
          cmp_q[gi].pin_drive <= wd[`CMPDAC_CMP_DRV_BIT];
          cmp_q[gi].invert    <= wd[`CMPDAC_CMP_INV_BIT];
        end else if (wr_ctrl_b) begin
          cmp_q[gi].rise_irq_on   <= wd[`CMPDAC_CMP_RISE_BIT];
          cmp_q[gi].fall_irq_on   <= wd[`CMPDAC_CMP_FALL_BIT];
          cmp_q[gi].pos_input_sel <= wd[`CMPDAC_CMP_PSEL_HI:0];
        end
      end
      assign cmp_cfg[gi] = cmp_q[gi];
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_q <= `CMPDAC_RST_REG;
    end else if (wr_irq_mask) begin
      irq_mask_q <= {6'h00, wd[1:0]};
    end
  end

  // ****************************************************************
  // Comparator channels
  // ****************************************************************
  logic [NUM_CMP-1:0] raw_sync;
  logic [NUM_CMP-1:0] result;
  logic [NUM_CMP-1:0] edge_set;

  cmpdac_sync #(
    .WIDTH   (NUM_CMP)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .async_in(cmp_raw),
    .sync_out(raw_sync)
  );

  generate
    for (gi = 0; gi < NUM_CMP; gi++) begin : g_chan
      cmpdac_chan u_chan (
        .aclk    (aclk),
        .aresetn (aresetn),
        .cfg     (cmp_q[gi]),
        .raw_sync(raw_sync[gi]),
        .result_q(result[gi]),
        .edge_set(edge_set[gi])
      );

      // Override follows the drive bit alone; a stopped comparator drives low
      assign cmp_pin_out[gi] = cmp_q[gi].pin_drive ? (cmp_q[gi].on & result[gi]) : port_latch[gi];
      assign cmp_pin_oe[gi]  = ~pin_direction[gi];
    end
  endgenerate

  // ****************************************************************
  // Interrupt status
  // ****************************************************************
  // A new edge in the clearing cycle keeps the flag set
  assign irq_set    = {6'h00, edge_set};
  assign stat_clr   = wr_irq_stat ? wd : 8'h00;
  assign irq_stat_d = (irq_stat_q & ~stat_clr) | irq_set;
  assign irq        = |(irq_stat_q & irq_mask_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= `CMPDAC_RST_REG;
    end else begin
      irq_stat_q <= irq_stat_d;
    end
  end

  // ****************************************************************
  // Read channel
  // ****************************************************************
  cmpdac_rd_state_t rd_state_q;
  logic [8:0]       rd_hit;
  logic [7:0]       rd_mux;
  logic [7:0]       dac_ctrl_rd;
  logic [7:0]       dac_level_rd;
  logic [7:0]       cmp_a_rd [NUM_CMP];
  logic [7:0]       cmp_b_rd [NUM_CMP];
  logic [7:0]       mirror_rd;
  logic             rd_miss;

  assign s_axi_arready = (rd_state_q == CMPDAC_RD_IDLE);
  assign rd_hit        = cmpdac_decode(s_axi_araddr);
  assign rd_miss       = (rd_hit == 9'h000);

  assign dac_ctrl_rd  = {dac_q.on, dac_q.lowpower_side_sel, dac_q.pin_drive, 1'b0,
                         dac_q.pos_source_sel, 1'b0, dac_q.neg_source_sel};
  assign dac_level_rd = {3'h0, dac_q.level};
  assign mirror_rd    = {6'h00, result};

  generate
    for (gi = 0; gi < NUM_CMP; gi++) begin : g_cmp_rd
      assign cmp_a_rd[gi] = {cmp_q[gi].on, result[gi], cmp_q[gi].pin_drive, cmp_q[gi].invert, 4'h0};
      assign cmp_b_rd[gi] = {cmp_q[gi].rise_irq_on, cmp_q[gi].fall_irq_on, 4'h0, cmp_q[gi].pos_input_sel};
    end
  endgenerate

  assign rd_mux = ({8{rd_hit[0]}} & dac_ctrl_rd)  |
                  ({8{rd_hit[1]}} & dac_level_rd) |
                  ({8{rd_hit[2]}} & cmp_a_rd[0])  |
                  ({8{rd_hit[3]}} & cmp_b_rd[0])  |
                  ({8{rd_hit[4]}} & cmp_a_rd[1])  |
                  ({8{rd_hit[5]}} & cmp_b_rd[1])  |
                  ({8{rd_hit[6]}} & mirror_rd)    |
                  ({8{rd_hit[7]}} & irq_stat_q)   |
                  ({8{rd_hit[8]}} & irq_mask_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_q   <= CMPDAC_RD_IDLE;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `CMPDAC_RESP_OKAY;
    end else begin
      case (rd_state_q)
        CMPDAC_RD_IDLE: begin
          if (s_axi_arvalid) begin
            rd_state_q   <= CMPDAC_RD_DATA;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rd_mux};
            s_axi_rresp  <= rd_miss ? `CMPDAC_RESP_SLVERR : `CMPDAC_RESP_OKAY;
          end
        end
        CMPDAC_RD_DATA: begin
          if (s_axi_rready) begin
            rd_state_q   <= CMPDAC_RD_IDLE;
            s_axi_rvalid <= 1'b0;
          end
        end
        default: begin
          rd_state_q   <= CMPDAC_RD_IDLE;
          s_axi_rvalid <= 1'b0;
        end
      endcase
    end
  end

endmodule : cmpdac_top
`default_nettype wire

//--- verif/cmpdac_props.sv
`timescale 1ns/1ps
`default_nettype none
module cmpdac_props
  import cmpdac_pkg::*;
#(
  parameter int NUM_CMP = 2
) (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic [31:0]        s_axi_rdata,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire logic [NUM_CMP-1:0] cmp_raw,
  input wire cmpdac_cmp_cfg_t    cmp_cfg [NUM_CMP],
  input wire cmpdac_dac_cfg_t    dac_cfg,
  input wire logic [NUM_CMP-1:0] pin_direction,
  input wire logic [NUM_CMP-1:0] port_latch,
  input wire logic [NUM_CMP-1:0] cmp_pin_out,
  input wire logic [NUM_CMP-1:0] cmp_pin_oe,
  input wire logic               irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  rst_clear_a: assert property ($rose(aresetn) |-> dac_cfg == '0 && cmp_cfg[0] == '0 && !irq)
    else $error("config or irq not clear after reset");
  pin_oe_a: assert property (cmp_pin_oe == ~pin_direction)
    else $error("pin enable does not follow direction");
  latch_pass_a: assert property (!cmp_cfg[0].pin_drive |-> cmp_pin_out[0] == port_latch[0])
    else $error("pin not showing port latch");
  pin_off_a: assert property (cmp_cfg[0].pin_drive && !cmp_cfg[0].on |-> !cmp_pin_out[0])
    else $error("disabled comparator drives pin high");
  // Four quiet cycles cover the two synchroniser stages plus the result flop
  pin_result_a: assert property (($stable(cmp_raw[0]) && $stable(cmp_cfg[0]) && cmp_cfg[0].on
    && cmp_cfg[0].pin_drive) [*4] |-> cmp_pin_out[0] == (cmp_raw[0] ^ cmp_cfg[0].invert))
    else $error("pin result differs from comparison");
  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read response late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before accept");
  rd_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && !s_axi_arready)
    else $error("read upper bits set or address accepted");
endmodule : cmpdac_props

bind cmpdac_top cmpdac_props #(.NUM_CMP(NUM_CMP)) u_props (.*);
`default_nettype wire

//--- verif/cmpdac_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module cmpdac_analog_model
  import cmpdac_pkg::*;
#(
  parameter int VDD_MV  = 3300,
  parameter int REFP_MV = 3000,
  parameter int REFN_MV = 500,
  parameter int BUF_MV  = 2048
) (
  input  wire cmpdac_cmp_cfg_t cmp_cfg [2],
  input  wire cmpdac_dac_cfg_t dac_cfg,
  output var  logic [1:0]      cmp_raw
);
  // ****************************************************************
  // Input voltages in millivolts, set by the bench
  // ****************************************************************
  int pin_mv [2] = '{0, 0};
  int neg_mv [2] = '{1500, 1500};
  int hi_mv, lo_mv, dac_mv;

  always_comb begin
    int pos;
    pos = 0;
    hi_mv = (dac_cfg.pos_source_sel == 2'h0) ? VDD_MV : (dac_cfg.pos_source_sel == 2'h1) ? REFP_MV
          : (dac_cfg.pos_source_sel == 2'h2) ? BUF_MV : 0;
    lo_mv = dac_cfg.neg_source_sel ? REFN_MV : 0;
    dac_mv = dac_cfg.on ? lo_mv + (hi_mv - lo_mv) * int'(dac_cfg.level) / 32 : lo_mv;
    for (int i = 0; i < 2; i++) begin
      pos = (cmp_cfg[i].pos_input_sel == 2'h0) ? pin_mv[i] : (cmp_cfg[i].pos_input_sel == 2'h1) ? dac_mv
          : (cmp_cfg[i].pos_input_sel == 2'h2) ? BUF_MV : 0;
      // A powered-down comparator gives no valid answer, so it shows a high level
      cmp_raw[i] = cmp_cfg[i].on ? (pos > neg_mv[i]) : 1'h1;
    end
  end
endmodule : cmpdac_analog_model
`default_nettype wire

//--- verif/cmpdac_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "cmpdac_consts.svh"
module cmpdac_top_test
  import cmpdac_pkg::*;
;
  logic            aclk = 1'h0;
  logic            aresetn = 1'h0;
  logic [5:0]      s_axi_awaddr = 6'h0, s_axi_araddr = 6'h0;
  logic [2:0]      s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0]     s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic [3:0]      s_axi_wstrb = 4'hF;
  logic            s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic            s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic            s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0]      s_axi_bresp, s_axi_rresp, cmp_raw, cmp_pin_out, cmp_pin_oe, rrsp;
  logic [1:0]      pin_direction = 2'h3, port_latch = 2'h0;
  cmpdac_cmp_cfg_t cmp_cfg [2];
  cmpdac_dac_cfg_t dac_cfg;
  int              errors = 0, cmp_count = 0, cyc = 0;

  cmpdac_top dut (.*);
  cmpdac_analog_model u_ana (.cmp_cfg(cmp_cfg), .dac_cfg(dac_cfg), .cmp_raw(cmp_raw));

  always #4 aclk = ~aclk;

  // ****************************************************************
  // Bus and compare helpers
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Ready of the write response channel stays high, so no strobe is lowered and raised in one step
  task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
    bit aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    chk(32'(s_axi_bresp), 32'(er));
  endtask : wr

  task automatic rd(input logic [5:0] a, input bit slow = 1'b0);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    if (slow) s_axi_rready <= 1'h0;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    if (slow) begin
      repeat (3) @(posedge aclk);
      s_axi_rready <= 1'h1;
    end
    do @(posedge aclk); while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    rrsp = s_axi_rresp;
  endtask : rd

  task automatic rchk(input logic [5:0] a, input logic [7:0] e, input bit slow = 1'b0);
    rd(a, slow);
    chk({30'h0, rrsp}, 32'h0);
    chk(rdat, {24'h0, e});
  endtask : rchk

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    for (int a = 0; a <= 32; a += 4) rchk(6'(a), 8'h00);
    chk(32'(dac_cfg), 32'h0);
  endtask : t_reset

  task automatic t_dac;
    wr(`CMPDAC_OFS_DAC_CTRL, 8'hFF);
    rchk(`CMPDAC_OFS_DAC_CTRL, 8'hED);
    wr(`CMPDAC_OFS_DAC_LEVEL, 8'hFF);
    rchk(`CMPDAC_OFS_DAC_LEVEL, 8'h1F);
    chk(32'(dac_cfg.level), 32'h1F);
    for (int p = 0; p < 4; p++) begin
      wr(`CMPDAC_OFS_DAC_CTRL, 8'(p << 2));
      chk(32'(dac_cfg.pos_source_sel), 32'(p));
      rchk(`CMPDAC_OFS_DAC_CTRL, 8'(p << 2));
    end
    wr(6'h3C, 8'h55, 2'h2);
    rd(6'h3C);
    chk({30'h0, rrsp} | rdat, 32'h2);
    wr(`CMPDAC_OFS_DAC_CTRL, 8'h00);
  endtask : t_dac

  task automatic t_cmp;
    for (int c = 0; c < 2; c++) begin
      for (int k = 0; k < 4; k++) begin
        u_ana.pin_mv[c] <= k[0] ? 2000 : 1000;
        wr(6'(8 + 8 * c), {3'h4, k[1], 4'h0});
        repeat (5) @(posedge aclk);
        rchk(6'(8 + 8 * c), {1'h1, k[0] ^ k[1], 1'h0, k[1], 4'h0});
        rchk(`CMPDAC_OFS_MIRROR, {7'h0, k[0] ^ k[1]} << c);
      end
      wr(6'(8 + 8 * c), 8'h00);
      repeat (5) @(posedge aclk);
      rchk(6'(8 + 8 * c), 8'h00);
    end
  endtask : t_cmp

  task automatic t_psel;
    int         lvl [4] = '{16, 8, 0, 0};
    logic [1:0] sel [4] = '{2'h1, 2'h1, 2'h2, 2'h3};
    logic [3:0] ex = 4'h5;
    u_ana.pin_mv[0] <= 1000;
    wr(`CMPDAC_OFS_DAC_CTRL, 8'h80);
    wr(`CMPDAC_OFS_CMP1_A, 8'h80);
    for (int i = 0; i < 4; i++) begin
      wr(`CMPDAC_OFS_DAC_LEVEL, 8'(lvl[i]));
      wr(`CMPDAC_OFS_CMP1_B, {6'h0, sel[i]});
      repeat (5) @(posedge aclk);
      rchk(`CMPDAC_OFS_CMP1_A, {1'h1, ex[i], 6'h0});
    end
    wr(`CMPDAC_OFS_CMP1_B, 8'h00);
    wr(`CMPDAC_OFS_DAC_CTRL, 8'h00);
  endtask : t_psel

  task automatic t_pin;
    u_ana.pin_mv[0] <= 2000;
    pin_direction <= 2'h2;
    wr(`CMPDAC_OFS_CMP1_A, 8'hA0);
    repeat (5) @(posedge aclk);
    chk(32'(cmp_pin_oe), 32'h1);
    chk(32'(cmp_pin_out), 32'h1);
    rchk(`CMPDAC_OFS_CMP1_A, 8'hE0, 1'b1);
    wr(`CMPDAC_OFS_CMP1_A, 8'h20);
    repeat (2) @(posedge aclk);
    chk(32'(cmp_pin_out), 32'h0);
    u_ana.pin_mv[0] <= 1000;
    port_latch <= 2'h1;
    wr(`CMPDAC_OFS_CMP1_A, 8'h80);
    repeat (5) @(posedge aclk);
    chk(32'(cmp_pin_out), 32'h1);
    port_latch <= 2'h0;
    pin_direction <= 2'h3;
  endtask : t_pin

  task automatic t_irq;
    wr(`CMPDAC_OFS_IRQ_MASK, 8'h01);
    wr(`CMPDAC_OFS_CMP1_B, 8'h80);
    wr(`CMPDAC_OFS_IRQ_STAT, 8'h03);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h0);
    u_ana.pin_mv[0] <= 2000;
    repeat (6) @(posedge aclk);
    chk(32'(irq), 32'h1);
    rchk(`CMPDAC_OFS_IRQ_STAT, 8'h01);
    wr(`CMPDAC_OFS_IRQ_STAT, 8'h01);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h0);
    rchk(`CMPDAC_OFS_IRQ_STAT, 8'h00);
    wr(`CMPDAC_OFS_IRQ_MASK, 8'h00);
    wr(`CMPDAC_OFS_CMP1_B, 8'h40);
    u_ana.pin_mv[0] <= 1000;
    repeat (6) @(posedge aclk);
    rchk(`CMPDAC_OFS_IRQ_STAT, 8'h01);
    chk(32'(irq), 32'h0);
    wr(`CMPDAC_OFS_CMP1_A, 8'h00);
  endtask : t_irq

  task automatic tally_and_finish;
    if (errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      tally_and_finish;
    end
  end

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_reset;
    t_dac;
    t_cmp;
    t_psel;
    t_pin;
    t_irq;
    tally_and_finish;
  end
endmodule : cmpdac_top_test
`default_nettype wire
